// *** rfc_config.sv ***
// serial command-word configuration logic: frame receiver, streamed transmit bytes,
// carrier channel word, receiver control word and baseband filter word
// assumes select_n, sck and sdi come from the host unsynchronised; strength and lock from local logic
// Operation
// (RULE_01) after one transmit command byte, further bytes under select load transmit data
// (RULE_02) sdo shows transmit-register-empty while streaming; host waits for it
// (RULE_03) code in bits 15..12 marks channel word; bits 11..0 are the channel
// (RULE_04) channel words outside 96..3903 are ignored, previous word kept
// (RULE_05) centre frequency is 10 * multiplier * (base + channel / 4000) MHz
// (RULE_06) code in bits 15..11 marks receiver control; low eleven bits configure
// (RULE_07) bit 10 picks multi-function pin: 0 interrupt input, 1 valid-data output
// (RULE_08) bits 9..8 set valid-data detector speed: fast, mid, slow, continuous
// (RULE_09) bandwidth code maps 1..6 to 400,340,270,200,134,67 kHz; 0 and 7 reserved
// (RULE_10) gain code maps to 0, -6, -14, -20 dB
// (RULE_11) strength compared with threshold -103 + 6 * code; result is status bit 7
// (RULE_12) effective threshold adds the magnitude of the gain setting
// (RULE_13) code in bits 15..8 marks baseband filter word; low byte configures
// (RULE_14) auto lock starts recovery fast, drops to slow once locked
// (RULE_15) manual bit picks fast or slow recovery; sender supplies enough preamble
// (RULE_16) host writes ones into bits 5 and 3 of the filter word
// (RULE_17) filter bit clear selects digital filter, set selects external analog filter
// (RULE_18) host keeps quality threshold below 4 when bit rate nears deviation
// (RULE_19) transmit register holds the byte to send, 0xaa after reset
// (RULE_20) frames shift msb first under select; payload applied when frame completes
`timescale 1ns/1ns
module rfc_config (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_select_n,
  input wire logic i_sck,
  input wire logic i_sdi,
  output logic o_sdo,
  input wire logic [1:0] i_band,
  input wire logic signed [8:0] i_strength_dbm,
  input wire logic i_recovery_locked,
  input wire logic i_tx_byte_done,
  output logic [7:0] o_tx_byte,
  output logic [11:0] o_channel_value,
  output logic [21:0] o_centre_half_khz,
  output rfc_pkg::rfc_rx_cfg_s o_rx_cfg,
  output rfc_pkg::rfc_bb_cfg_s o_bb_cfg,
  output logic o_status_strength
);
  typedef enum {RFC_IDLE, RFC_FRAME, RFC_STREAM, RFC_HOLD} rfc_state_e;

  // pin synchronisers; stage one is read by stage two only
  logic [2:0] sck_sync_reg, cs_sync_reg;
  logic [1:0] sdi_sync_reg;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sck_sync_reg <= 3'h0;
      cs_sync_reg <= 3'h7;
      sdi_sync_reg <= 2'h0;
    end else begin
      sck_sync_reg <= {sck_sync_reg[1:0], i_sck};
      cs_sync_reg <= {cs_sync_reg[1:0], i_select_n};
      sdi_sync_reg <= {sdi_sync_reg[0], i_sdi};
    end
  end
  logic sck_rise, cs_low;
  assign sck_rise = sck_sync_reg[1] && !sck_sync_reg[2];
  assign cs_low = !cs_sync_reg[1];

  // frame receiver
  rfc_state_e state_reg, state_next;
  logic [15:0] shift_reg, shift_next;
  logic [4:0] cnt_reg, cnt_next;
  logic frame_done, stream_push;
  logic [15:0] shifted;
  assign shifted = {shift_reg[14:0], sdi_sync_reg[1]}; // see (RULE_20)

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    frame_done = 1'b0;
    stream_push = 1'b0;
    unique case (state_reg)
      RFC_IDLE: begin
        cnt_next = 5'h00;
        if (cs_low) begin
          state_next = RFC_FRAME;
        end
      end
      RFC_FRAME: begin
        if (!cs_low) begin
          state_next = RFC_IDLE;
        end else if (sck_rise) begin
          shift_next = shifted;
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == 5'(rfc_pkg::BYTE_BITS - 1) && shifted[7:0] == rfc_pkg::CMD_TX_BYTE) begin
            state_next = RFC_STREAM; // see (RULE_01)
            cnt_next = 5'h00;
          end else if (cnt_reg == 5'(rfc_pkg::FRAME_BITS - 1)) begin
            frame_done = 1'b1; // see (RULE_20)
            state_next = RFC_HOLD;
          end
        end
      end
      RFC_STREAM: begin
        if (!cs_low) begin
          state_next = RFC_IDLE;
        end else if (sck_rise) begin
          shift_next = shifted;
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == 5'(rfc_pkg::BYTE_BITS - 1)) begin
            stream_push = 1'b1; // see (RULE_01)
            cnt_next = 5'h00;
          end
        end
      end
      RFC_HOLD: begin
        // extra clocks past sixteen bits are ignored until select rises
        if (!cs_low) begin
          state_next = RFC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg <= RFC_IDLE;
      shift_reg <= 16'h0000;
      cnt_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
    end
  end

  // streamed transmit bytes; a byte sent while the buffer is full is lost, so the host must watch sdo
  logic fifo_in_ready, fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic tx_pop;
  logic [7:0] tx_byte_reg, tx_byte_next;
  assign tx_pop = i_tx_byte_done && fifo_out_valid;
  rfc_fifo #(.WIDTH(rfc_pkg::BYTE_BITS), .DEPTH(rfc_pkg::TX_FIFO_DEPTH)) u_tx_fifo (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_in_valid(stream_push),
    .o_in_ready(fifo_in_ready),
    .i_in_data(shifted[7:0]),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(i_tx_byte_done),
    .o_out_data(fifo_out_data)
  );
  always_comb begin
    tx_byte_next = tx_byte_reg;
    if (tx_pop) begin
      tx_byte_next = fifo_out_data; // see (RULE_19)
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      tx_byte_reg <= rfc_pkg::TX_BYTE_RESET; // see (RULE_19)
    end else begin
      tx_byte_reg <= tx_byte_next;
    end
  end
  assign o_tx_byte = tx_byte_reg;
  assign o_sdo = (state_reg == RFC_STREAM) && fifo_in_ready; // see (RULE_02)

  // command words
  logic [15:0] freq_reg, freq_next, rx_reg, rx_next, bb_reg, bb_next;
  logic freq_hit, chan_ok;
  assign freq_hit = frame_done && shifted[15:12] == rfc_pkg::CMD_FREQ; // see (RULE_03)
  assign chan_ok = shifted[11:0] >= rfc_pkg::CHAN_MIN && shifted[11:0] <= rfc_pkg::CHAN_MAX; // see (RULE_04)
  always_comb begin
    freq_next = freq_reg;
    rx_next = rx_reg;
    bb_next = bb_reg;
    if (freq_hit && chan_ok) begin
      freq_next = shifted; // see (RULE_04)
    end
    if (frame_done && shifted[15:11] == rfc_pkg::CMD_RX_CTRL) begin
      rx_next = shifted; // see (RULE_06)
    end
    if (frame_done && shifted[15:8] == rfc_pkg::CMD_BB_FILTER_TYPE_SELECT) begin
      bb_next = shifted; // see (RULE_13)
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      freq_reg <= rfc_pkg::FREQ_RESET;
      rx_reg <= rfc_pkg::RX_CTRL_RESET;
      bb_reg <= rfc_pkg::BB_FILTER_TYPE_SELECT_RESET;
    end else begin
      freq_reg <= freq_next;
      rx_reg <= rx_next;
      bb_reg <= bb_next;
    end
  end
  assign o_channel_value = freq_reg[11:0];

  // centre frequency: 10 MHz * b1 * (b0 + chan / 4000) in half-kHz steps
  logic [1:0] band_multiplier;
  logic [5:0] band_base;
  logic [21:0] centre_next, centre_reg;
  always_comb begin
    unique case (i_band)
      2'h0: begin
        band_multiplier = 2'h1;
        band_base = 6'h1f;
      end
      2'h1: begin
        band_multiplier = 2'h1;
        band_base = 6'h2b;
      end
      2'h2: begin
        band_multiplier = 2'h2;
        band_base = 6'h2b;
      end
      2'h3: begin
        band_multiplier = 2'h3;
        band_base = 6'h1e;
      end
    endcase
    centre_next = 22'(band_multiplier * (22'(band_base) * rfc_pkg::HALF_KHZ_PER_MHZ10 +
                  22'(freq_reg[11:0]) * rfc_pkg::HALF_KHZ_PER_CHAN)); // see (RULE_05)
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      centre_reg <= 22'h000000;
    end else begin
      centre_reg <= centre_next;
    end
  end
  assign o_centre_half_khz = centre_reg;

  // receiver control decode
  rfc_pkg::rfc_rx_cfg_s rx_cfg;
  logic [2:0] thr_code;
  always_comb begin
    thr_code = rx_reg[rfc_pkg::RX_THR_LSB +: 3];
    rx_cfg.pin_role_select = rx_reg[rfc_pkg::RX_ROLE_BIT]; // see (RULE_07)
    rx_cfg.valid_detect_speed = rfc_pkg::rfc_vds_e'(rx_reg[rfc_pkg::RX_VDS_LSB +: 2]); // see (RULE_08)
    unique case (rx_reg[rfc_pkg::RX_BW_LSB +: 3])
      3'h1: rx_cfg.baseband_bw_khz = 9'h190; // see (RULE_09)
      3'h2: rx_cfg.baseband_bw_khz = 9'h154;
      3'h3: rx_cfg.baseband_bw_khz = 9'h10e;
      3'h4: rx_cfg.baseband_bw_khz = 9'h0c8;
      3'h5: rx_cfg.baseband_bw_khz = 9'h086;
      3'h6: rx_cfg.baseband_bw_khz = 9'h043;
      default: rx_cfg.baseband_bw_khz = 9'h000;
    endcase
    unique case (rx_reg[rfc_pkg::RX_GAIN_LSB +: 2])
      2'h0: rx_cfg.lna_gain_db = 5'h00; // see (RULE_10)
      2'h1: rx_cfg.lna_gain_db = 5'h06;
      2'h2: rx_cfg.lna_gain_db = 5'h0e;
      2'h3: rx_cfg.lna_gain_db = 5'h14;
    endcase
    rx_cfg.strength_threshold_dbm = 9'(rfc_pkg::THR_BASE + rfc_pkg::THR_STEP * $signed({1'b0, thr_code}) +
                                      $signed({4'h0, rx_cfg.lna_gain_db})); // see (RULE_11) (RULE_12)
    rx_cfg.reserved_code = thr_code > rfc_pkg::THR_LAST || rx_cfg.baseband_bw_khz == 9'h000;
  end
  assign o_rx_cfg = rx_cfg;

  // strength comparison; a reserved threshold code never reports strength
  logic strength_reg, strength_next;
  always_comb begin
    // thresholds are below zero, so the comparison must stay signed
    strength_next = (thr_code <= rfc_pkg::THR_LAST) &&
                    (i_strength_dbm >= $signed(rx_cfg.strength_threshold_dbm)); // see (RULE_11)
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      strength_reg <= 1'b0;
    end else begin
      strength_reg <= strength_next;
    end
  end
  assign o_status_strength = strength_reg;

  // clock recovery lock: auto mode starts fast and falls to slow on lock
  logic auto_fast_reg, auto_fast_next;
  logic bb_written;
  // every filter command restarts the fast phase, even one that repeats the stored word
  assign bb_written = frame_done && shifted[15:8] == rfc_pkg::CMD_BB_FILTER_TYPE_SELECT;
  always_comb begin
    auto_fast_next = auto_fast_reg;
    if (bb_written) begin
      auto_fast_next = 1'b1; // see (RULE_14)
    end else if (i_recovery_locked) begin
      auto_fast_next = 1'b0; // see (RULE_14)
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      auto_fast_reg <= 1'b1;
    end else begin
      auto_fast_reg <= auto_fast_next;
    end
  end
  // bits 5 and 3 of the filter word are the host's concern and are not looked at
  always_comb begin
    if (bb_reg[rfc_pkg::BB_AUTO_BIT]) begin
      o_bb_cfg.recovery_fast = auto_fast_reg; // see (RULE_14)
    end else begin
      o_bb_cfg.recovery_fast = bb_reg[rfc_pkg::BB_FAST_BIT]; // see (RULE_15)
    end
    o_bb_cfg.filter_type_select = bb_reg[rfc_pkg::BB_FILTER_TYPE_SELECT_BIT]; // see (RULE_17)
    o_bb_cfg.quality_threshold = bb_reg[rfc_pkg::BB_DQ_LSB +: 3];
  end

  // checks
  sequence s_freq_bad;
    freq_hit && !chan_ok;
  endsequence
  sequence s_freq_good;
    freq_hit && chan_ok;
  endsequence
  chk_freq_range_keep: assert property (@(posedge i_clock) disable iff (i_rst) // see (RULE_04)
    s_freq_bad |=> $stable(o_channel_value)) else $error("out of range channel word was taken");
  chk_freq_accept: assert property (@(posedge i_clock) disable iff (i_rst) // see (RULE_03)
    s_freq_good |=> o_channel_value == $past(shifted[11:0])) else $error("channel word not stored");
  // the first cycle after reset still compares against the cleared centre register
  chk_centre_follow: assert property (@(posedge i_clock) disable iff (i_rst) // see (RULE_05)
    !$past(i_rst) && $stable(i_band) && $stable(o_channel_value) |=> $stable(o_centre_half_khz))
    else $error("centre moved");
  chk_sdo_empty_flag: assert property (@(posedge i_clock) disable iff (i_rst) // see (RULE_02)
    state_reg != RFC_STREAM |-> !o_sdo) else $error("sdo raised outside stream");
  chk_stream_byte_load: assert property (@(posedge i_clock) disable iff (i_rst) // see (RULE_01)
    stream_push && fifo_in_ready && !tx_pop |=> fifo_out_valid) else $error("streamed byte not buffered");
  chk_tx_load: assert property (@(posedge i_clock) disable iff (i_rst) // see (RULE_19)
    tx_pop |=> o_tx_byte == $past(fifo_out_data)) else $error("transmit byte not loaded");
  chk_auto_lock_slow: assert property (@(posedge i_clock) disable iff (i_rst) // see (RULE_14)
    bb_reg[rfc_pkg::BB_AUTO_BIT] && i_recovery_locked && !bb_written ##1 bb_reg[rfc_pkg::BB_AUTO_BIT]
    |-> !o_bb_cfg.recovery_fast) else $error("auto lock stayed fast");
  chk_rx_apply: assert property (@(posedge i_clock) disable iff (i_rst) // see (RULE_06)
    frame_done && shifted[15:11] == rfc_pkg::CMD_RX_CTRL |=> o_rx_cfg.pin_role_select == $past(shifted[10]))
    else $error("receiver word not applied");
  chk_strength_flag: assert property (@(posedge i_clock) disable iff (i_rst) // see (RULE_11)
    thr_code > rfc_pkg::THR_LAST |=> !o_status_strength) else $error("strength flag on reserved code");
  sequence s_frame_cut;
    state_reg == RFC_FRAME && !cs_low;
  endsequence
  sequence s_tx_command;
    state_reg == RFC_FRAME && cs_low && sck_rise && cnt_reg == 5'(rfc_pkg::BYTE_BITS - 1) &&
    shifted[7:0] == rfc_pkg::CMD_TX_BYTE;
  endsequence
  chk_frame_cut_drop: assert property (@(posedge i_clock) disable iff (i_rst) // see (RULE_20)
    s_frame_cut |=> state_reg == RFC_IDLE && $stable(freq_reg) && $stable(rx_reg) && $stable(bb_reg))
    else $error("cut frame was applied");
  chk_stream_entry: assert property (@(posedge i_clock) disable iff (i_rst) // see (RULE_01)
    s_tx_command |=> state_reg == RFC_STREAM && cnt_reg == 5'h00) else $error("stream mode not entered");
  chk_filter_apply: assert property (@(posedge i_clock) disable iff (i_rst) // see (RULE_17)
    frame_done && shifted[15:8] == rfc_pkg::CMD_BB_FILTER_TYPE_SELECT |=>
    o_bb_cfg.filter_type_select == $past(shifted[rfc_pkg::BB_FILTER_TYPE_SELECT_BIT])) else $error("filter word not applied");
endmodule : rfc_config

// *** rfc_config_tb.sv ***
// self-checking bench for the serial command registers
// assumes rfc_host drives the serial pins; the bench drives the local inputs
`timescale 1ns/1ns
module rfc_config_tb;
  logic i_clock, i_rst, select_n, sck, sdi, sdo, locked, tx_done, status, ok;
  logic [1:0] band;
  logic signed [8:0] strength, thr;
  logic [7:0] tx_byte;
  logic [11:0] chan, ch, exp_ch;
  logic [21:0] centre;
  logic [10:0] f;
  logic [7:0] q [8];
  rfc_pkg::rfc_rx_cfg_s rx_cfg;
  rfc_pkg::rfc_bb_cfg_s bb_cfg;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;

  rfc_config uut (.i_clock(i_clock), .i_rst(i_rst), .i_select_n(select_n), .i_sck(sck), .i_sdi(sdi),
    .o_sdo(sdo), .i_band(band), .i_strength_dbm(strength), .i_recovery_locked(locked),
    .i_tx_byte_done(tx_done), .o_tx_byte(tx_byte), .o_channel_value(chan), .o_centre_half_khz(centre),
    .o_rx_cfg(rx_cfg), .o_bb_cfg(bb_cfg), .o_status_strength(status));
  rfc_host host (.i_clock(i_clock), .i_sdo(sdo), .o_select_n(select_n), .o_sck(sck), .o_sdi(sdi));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  function automatic logic [21:0] exp_centre(input logic [1:0] b, input logic [11:0] c);
    int m;
    int base;
    m = (b == 2'h3) ? 3 : (b == 2'h2) ? 2 : 1;
    base = (b == 2'h0) ? 31 : (b == 2'h3) ? 30 : 43;
    return 22'(m * (base * 20000 + c * 5));
  endfunction : exp_centre

  function automatic logic [8:0] exp_bw(input logic [2:0] c);
    case (c)
      3'h1: return 9'd400;
      3'h2: return 9'd340;
      3'h3: return 9'd270;
      3'h4: return 9'd200;
      3'h5: return 9'd134;
      3'h6: return 9'd67;
      default: return 9'd0;
    endcase
  endfunction : exp_bw

  function automatic logic [4:0] exp_gain(input logic [1:0] c);
    return (c == 2'h0) ? 5'd0 : (c == 2'h1) ? 5'd6 : (c == 2'h2) ? 5'd14 : 5'd20;
  endfunction : exp_gain

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : wait_clk

  task automatic pulse_done();
    @(posedge i_clock) tx_done <= 1'b1;
    @(posedge i_clock) tx_done <= 1'b0;
    wait_clk(2);
  endtask : pulse_done

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      conclude();
    end
  end

  initial begin
    i_rst = 1'b1;
    band = 2'h0;
    strength = '0;
    locked = 1'b0;
    tx_done = 1'b0;
    void'($urandom(41));
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
    wait_clk(4);
    chk("tx_byte", 8'haa, tx_byte);
    chk("channel", 12'h680, chan);
    chk("centre", exp_centre(2'h0, 12'h680), centre);
    chk("bw", 9'd200, rx_cfg.baseband_bw_khz);
    chk("thr", {23'h0, -9'sd103}, {23'h0, rx_cfg.strength_threshold_dbm});
    chk("fast", 1'b0, bb_cfg.recovery_fast);
    chk("quality", 3'h4, bb_cfg.quality_threshold);
    chk("sdo idle", 1'b0, sdo);
    pulse_done();
    chk("tx_byte empty", 8'haa, tx_byte);
    $display("test reset done");

    exp_ch = 12'h680;
    for (int i = 0; i < 16; i++) begin
      ch = (i == 0) ? 12'd96 : (i == 1) ? 12'd3903 : (i == 2) ? 12'd95 : (i == 3) ? 12'd3904 :
           (i == 4) ? 12'h000 : (i == 5) ? 12'hfff : 12'(96 + $urandom % 3808);
      @(posedge i_clock) band <= 2'($urandom);
      host.frame({rfc_pkg::CMD_FREQ, ch}, 16);
      if (ch >= 12'd96 && ch <= 12'd3903) exp_ch = ch;
      wait_clk(6);
      chk("channel", exp_ch, chan);
      chk("centre", exp_centre(band, exp_ch), centre);
    end
    host.frame(16'({rfc_pkg::CMD_FREQ, 12'd500} >> 6), 10);
    host.frame(16'h0123, 16);
    wait_clk(6);
    chk("channel partial", exp_ch, chan);
    $display("test frequency done");

    for (int i = 0; i < 16; i++) begin
      f = (i < 8) ? {i[0], i[1:0], i[2:0], i[1:0], i[2:0]} : 11'($urandom);
      host.frame({rfc_pkg::CMD_RX_CTRL, f}, 16);
      thr = -9'sd103 + 9'sd6 * $signed({6'h00, f[2:0]}) + $signed({4'h0, exp_gain(f[4:3])});
      @(posedge i_clock) strength <= thr + 9'($signed($urandom % 3) - 1);
      wait_clk(4);
      chk("role", f[10], rx_cfg.pin_role_select);
      chk("vds", f[9:8], rx_cfg.valid_detect_speed);
      chk("bw", exp_bw(f[7:5]), rx_cfg.baseband_bw_khz);
      chk("gain", exp_gain(f[4:3]), rx_cfg.lna_gain_db);
      if (f[2:0] <= 3'h5) chk("thr", {23'h0, thr}, {23'h0, rx_cfg.strength_threshold_dbm});
      chk("reserved", (f[2:0] > 3'h5) || (exp_bw(f[7:5]) == 9'd0), rx_cfg.reserved_code);
      chk("strength", (f[2:0] <= 3'h5) && (strength >= thr), status);
    end
    $display("test receiver done");

    for (int i = 0; i < 16; i++) begin
      f = 11'($urandom % ((i < 8) ? 4 : 8));
      host.frame({rfc_pkg::CMD_BB_FILTER_TYPE_SELECT, i[3], i[2], 1'b1, i[1], 1'b1, f[2:0]}, 16);
      wait_clk(6);
      chk("filter", i[1], bb_cfg.filter_type_select);
      chk("quality", f[2:0], bb_cfg.quality_threshold);
      chk("fast", i[3] | i[2], bb_cfg.recovery_fast);
      if (i[3]) begin
        @(posedge i_clock) locked <= 1'b1;
        wait_clk(4);
        chk("fast locked", 1'b0, bb_cfg.recovery_fast);
        @(posedge i_clock) locked <= 1'b0;
      end
    end
    $display("test filter done");

    host.stream_open();
    wait_clk(6);
    chk("sdo empty", 1'b1, sdo);
    for (int i = 0; i < 8; i++) begin
      q[i] = 8'($urandom);
      host.stream_byte(q[i], 1'b1, ok);
      chk("ready seen", 1'b1, ok);
    end
    wait_clk(6);
    chk("sdo full", 1'b0, sdo);
    host.stream_byte(~q[7], 1'b0, ok);
    host.close_sel();
    for (int i = 0; i < 9; i++) begin
      pulse_done();
      chk("tx_byte", q[(i < 8) ? i : 7], tx_byte);
    end
    chk("sdo closed", 1'b0, sdo);
    host.frame({rfc_pkg::CMD_FREQ, 12'd1000}, 16);
    wait_clk(6);
    chk("channel after stream", 12'd1000, chan);
    $display("test stream done");
    conclude();
  end
endmodule : rfc_config_tb

// *** rfc_fifo.sv ***
// parameterised first-in first-out buffer with valid/ready on both sides
// assumes a single clock and a synchronous active-high reset
`timescale 1ns/1ns
module rfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  assign o_in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data = mem_reg[rd_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // storage carries no reset; contents only count once pushed
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_reg[wr_reg] <= i_in_data;
    end
  end
endmodule : rfc_fifo

// *** rfc_host.sv ***
// host model: shifts command frames and streamed transmit bytes onto the serial pins
// assumes i_clock is the device clock; used only to bound the wait on o_sdo
`timescale 1ns/1ns
module rfc_host (
  input wire logic i_clock,
  input wire logic i_sdo,
  output logic o_select_n,
  output logic o_sck,
  output logic o_sdi
);
  initial begin
    o_select_n = 1'b1;
    o_sck = 1'b0;
    o_sdi = 1'b0;
  end

  // sck stands still outside frames; 125 ns period inside them
  task automatic shift(input logic [15:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      o_sdi <= w[i];
      #62 o_sck <= 1'b1;
      #63 o_sck <= 1'b0;
    end
  endtask : shift

  task automatic open_sel();
    o_select_n <= 1'b0;
    #100;
  endtask : open_sel

  // a released data line must not keep showing the last bit
  task automatic close_sel();
    #60 o_select_n <= 1'b1;
    o_sdi <= ~o_sdi;
    #100;
  endtask : close_sel

  task automatic frame(input logic [15:0] w, input int n);
    open_sel();
    shift(w, n);
    close_sel();
  endtask : frame

  task automatic stream_open();
    open_sel();
    shift({8'h00, rfc_pkg::CMD_TX_BYTE}, 8);
  endtask : stream_open

  // wait_ready low sends regardless of the empty flag, to provoke a refusal
  task automatic stream_byte(input logic [7:0] b, input bit wait_ready, output bit ok);
    ok = 1'b1;
    if (wait_ready) begin
      ok = 1'b0;
      for (int i = 0; i < 400 && !ok; i++) begin
        @(posedge i_clock);
        #1;
        ok = (i_sdo === 1'b1);
      end
    end
    shift({8'h00, b}, 8);
  endtask : stream_byte
endmodule : rfc_host

// *** rfc_pkg.sv ***
// constants, field layouts and carrier types of the serial command registers
// assumes 16-bit command frames shifted msb first by the host
package rfc_pkg;
  localparam int FRAME_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int TX_FIFO_DEPTH = 8;
  // command codes and their widths
  localparam logic [7:0] CMD_TX_BYTE = 8'hb8;
  localparam logic [3:0] CMD_FREQ = 4'ha;
  localparam logic [4:0] CMD_RX_CTRL = 5'h12;
  localparam logic [7:0] CMD_BB_FILTER_TYPE_SELECT = 8'hc2;
  // values after reset
  localparam logic [15:0] FREQ_RESET = 16'ha680;
  localparam logic [15:0] RX_CTRL_RESET = 16'h9080;
  localparam logic [15:0] BB_FILTER_TYPE_SELECT_RESET = 16'hc22c;
  localparam logic [7:0] TX_BYTE_RESET = 8'haa;
  // channel word limits
  localparam logic [11:0] CHAN_MIN = 12'h060;
  localparam logic [11:0] CHAN_MAX = 12'hf3f;
  localparam logic [15:0] CHAN_DIVISOR = 16'h0fa0;
  // field positions in the receiver control word
  localparam int RX_ROLE_BIT = 10;
  localparam int RX_VDS_LSB = 8;
  localparam int RX_BW_LSB = 5;
  localparam int RX_GAIN_LSB = 3;
  localparam int RX_THR_LSB = 0;
  // field positions in the baseband filter word
  localparam int BB_AUTO_BIT = 7;
  localparam int BB_FAST_BIT = 6;
  localparam int BB_FILTER_TYPE_SELECT_BIT = 4;
  localparam int BB_DQ_LSB = 0;
  // signal strength threshold: base and step in dBm
  localparam logic signed [8:0] THR_BASE = -9'sd103;
  localparam logic signed [8:0] THR_STEP = 9'sd6;
  localparam logic [2:0] THR_LAST = 3'h5;
  // frequency in half-kHz units: b1 * (b0 * 20000 + chan * 5)
  localparam logic [15:0] HALF_KHZ_PER_MHZ10 = 16'h4e20;
  localparam logic [3:0] HALF_KHZ_PER_CHAN = 4'h5;

  typedef enum logic [1:0] {RFC_VDS_FAST, RFC_VDS_MID, RFC_VDS_SLOW, RFC_VDS_CONT} rfc_vds_e;

  typedef struct packed {
    logic pin_role_select;
    rfc_vds_e valid_detect_speed;
    logic [8:0] baseband_bw_khz;
    logic [4:0] lna_gain_db;
    logic signed [8:0] strength_threshold_dbm;
    logic reserved_code;
  } rfc_rx_cfg_s;

  typedef struct packed {
    logic recovery_fast;
    logic filter_type_select;
    logic [2:0] quality_threshold;
  } rfc_bb_cfg_s;
endpackage : rfc_pkg
